/* File: hw/sync_gen_defs.svh */
// register map, field positions, reset values and serial framing for the sync pulse generator
// Function
// - in CMOS mode each of the two sync pins has its own enable bit, driving when set and tristate when clear.
// - one configuration bit picks the output driver, clear for differential LVPECL (default) and set for CMOS.
// - the sync clock is resampled on the distribution divider clock, rising edge for 0 (default), falling for 1.
// - one sync interval lasts the 16-bit divider value plus one cycles of the selected source clock, from 1 to 65536.
// - the 16-bit interval divider sits in two byte registers, low byte at 0x190 and high byte at 0x191.
// - setting the sync enable bit starts the pattern of the two-bit mode field: a single shot (00), a periodic clock (01) or pseudorandom (1x).
// - a two-bit source field picks the reference (00), the feedback divider (01), or powers sync down (1x).
// - in CMOS mode pin a's polarity follows the main polarity bit, and pin b's the CMOS polarity bit combined with the main one.
// - writing 1 to the self-clearing transfer bit copies buffered settings to the active ones at the next serial clock rise.
`ifndef SYNC_GEN_DEFS_SVH
`define SYNC_GEN_DEFS_SVH

// register addresses on the serial port
`define ADDR_SYNC_POLARITY 13'h0f8
`define ADDR_SYNC_OUTPUT_CMOS_CONFIG 13'h0f9
`define ADDR_SYNC_INTERVAL_LOW 13'h190
`define ADDR_SYNC_INTERVAL_HIGH 13'h191
`define ADDR_SYNC_GENERATOR_CONTROL 13'h192
`define ADDR_TRANSFER 13'h232

// field positions
`define POL_MAIN_BIT 3
`define CMOS_POL_BIT 4
`define CMOS_EN_HI 3
`define CMOS_EN_LO 2
`define CMOS_MODE_BIT 1
`define EDGE_SEL_BIT 0
`define CTRL_ENABLE_BIT 4
`define CTRL_SOURCE_HI 3
`define CTRL_SOURCE_LO 2
`define CTRL_MODE_HI 1
`define CTRL_MODE_LO 0
`define TRANSFER_BIT 0

// reset value of every held field
`define SYNC_CFG_RESET 27'h0000000

// serial framing: 16 instruction bits then 8 data bits
`define INSTR_LAST 5'h0f
`define DATA_LAST 5'h07
`define INSTR_READ_BIT 15

// pseudorandom generator seed
`define LFSR_SEED 16'hace1

`endif

/* File: hw/sync_gen_pkg.sv */
// types shared by the sync pulse generator
package sync_gen_pkg;

	// settings held twice: buffered by writes, active after a transfer
	typedef struct packed {
		logic [15:0] interval;
		logic enable;
		logic [1:0] source;
		logic [1:0] mode;
		logic polarity;
		logic cmos_pol;
		logic [1:0] cmos_en;
		logic cmos_mode;
		logic edge_fall;
	} sync_cfg_t;

	typedef enum logic [1:0] {
		SRC_REF = 2'h0,
		SRC_FEEDBACK = 2'h1
	} sync_source_t;

	typedef enum logic [1:0] {
		MODE_SINGLE = 2'h0,
		MODE_PERIODIC = 2'h1
	} sync_mode_t;

	// serial port framing, gray along instruction -> data -> done
	typedef enum logic [1:0] {
		SPI_INSTR = 2'h0,
		SPI_DATA = 2'h1,
		SPI_DONE = 2'h3
	} spi_state_t;

	// single-shot progress, gray along idle -> wait -> high -> done
	typedef enum logic [1:0] {
		SHOT_IDLE = 2'h0,
		SHOT_WAIT = 2'h1,
		SHOT_HIGH = 2'h3,
		SHOT_DONE = 2'h2
	} shot_state_t;

endpackage : sync_gen_pkg

/* File: hw/sync_interval_timer.sv */
// counts source clock edges and pulses once every programmed interval
`timescale 1ns/100ps
`default_nettype none

module sync_interval_timer #(
	parameter int WIDTH = 16
) (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_run,
	input wire logic i_step,
	input wire logic [WIDTH-1:0] i_limit,
	output logic o_tick
);

	logic [WIDTH-1:0] count_reg;
	logic [WIDTH-1:0] count_next;
	wire at_limit = (count_reg == i_limit);

	// count wraps after limit+1 steps, so a limit of zero ticks on every step
	assign count_next = at_limit ? '0 : count_reg + {{(WIDTH-1){1'b0}}, 1'b1};

	always_ff @(posedge i_clk) begin
		if (!i_reset_n || !i_run) begin
			count_reg <= '0;
			o_tick <= 1'b0;
		end else begin
			o_tick <= i_step && at_limit;
			if (i_step) begin
				count_reg <= count_next;
			end
		end
	end

endmodule : sync_interval_timer

`default_nettype wire

/* File: hw/sync_pulse_generator.sv */
// sync pulse generator: serial register port, interval timer, mode logic and output stage
`timescale 1ns/100ps
`default_nettype none
`include "sync_gen_defs.svh"

module sync_pulse_generator (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_sclk,
	input wire logic i_cs_n,
	input wire logic i_sdi,
	output logic o_sdo,
	input wire logic i_ref_clk,
	input wire logic i_feedback_divider_output,
	input wire logic i_dist_clk,
	output logic o_sync_a,
	output logic o_sync_a_oe,
	output logic o_sync_b,
	output logic o_sync_b_oe
);

	sync_gen_pkg::sync_cfg_t buf_reg;
	sync_gen_pkg::sync_cfg_t act_reg;
	sync_gen_pkg::spi_state_t spi_state_reg;
	sync_gen_pkg::shot_state_t shot_state_reg;
	logic sclk_prev_reg;
	logic [4:0] bit_cnt_reg;
	logic [14:0] shift_reg;
	logic [15:0] instr_reg;
	logic [7:0] rd_shift_reg;
	logic xfer_pend_reg;
	logic ref_prev_reg;
	logic fb_prev_reg;
	logic dist_prev_reg;
	logic enable_prev_reg;
	logic raw_reg;
	logic resamp_reg;
	logic [15:0] lfsr_reg;
	logic tick;

	// read mux over the buffered settings; unmapped addresses read zero
	function automatic logic [7:0] read_byte(input logic [12:0] addr,
			input sync_gen_pkg::sync_cfg_t c, input logic pend);
		logic [7:0] d;
		d = 8'h00;
		if (addr == `ADDR_SYNC_POLARITY) begin
			d[`POL_MAIN_BIT] = c.polarity;
		end else if (addr == `ADDR_SYNC_OUTPUT_CMOS_CONFIG) begin
			d[`CMOS_POL_BIT] = c.cmos_pol;
			d[`CMOS_EN_HI:`CMOS_EN_LO] = c.cmos_en;
			d[`CMOS_MODE_BIT] = c.cmos_mode;
			d[`EDGE_SEL_BIT] = c.edge_fall;
		end else if (addr == `ADDR_SYNC_INTERVAL_LOW) begin
			d = c.interval[7:0];
		end else if (addr == `ADDR_SYNC_INTERVAL_HIGH) begin
			d = c.interval[15:8];
		end else if (addr == `ADDR_SYNC_GENERATOR_CONTROL) begin
			d[`CTRL_ENABLE_BIT] = c.enable;
			d[`CTRL_SOURCE_HI:`CTRL_SOURCE_LO] = c.source;
			d[`CTRL_MODE_HI:`CTRL_MODE_LO] = c.mode;
		end else if (addr == `ADDR_TRANSFER) begin
			d[`TRANSFER_BIT] = pend;
		end
		return d;
	endfunction : read_byte

	// serial clock edges; all pins are synchronous to i_clk
	wire sclk_rise = i_sclk && !sclk_prev_reg;
	wire sclk_fall = !i_sclk && sclk_prev_reg;
	wire instr_done = sclk_rise && (spi_state_reg == sync_gen_pkg::SPI_INSTR)
		&& (bit_cnt_reg == `INSTR_LAST);
	wire data_done = sclk_rise && (spi_state_reg == sync_gen_pkg::SPI_DATA)
		&& (bit_cnt_reg == `DATA_LAST);
	wire [15:0] instr_word = {shift_reg, i_sdi};
	wire [12:0] wr_addr = instr_reg[12:0];
	wire [7:0] wr_data = {shift_reg[6:0], i_sdi};
	wire wr_fire = data_done && !instr_reg[`INSTR_READ_BIT];
	wire xfer_now = sclk_rise && xfer_pend_reg;
	wire xfer_set = wr_fire && (wr_addr == `ADDR_TRANSFER) && wr_data[`TRANSFER_BIT];

	// serial framing: instruction then one data byte, rest of frame ignored
	always_ff @(posedge i_clk) begin
		if (!i_reset_n || i_cs_n) begin
			spi_state_reg <= sync_gen_pkg::SPI_INSTR;
			bit_cnt_reg <= 5'h00;
		end else if (instr_done) begin
			spi_state_reg <= sync_gen_pkg::SPI_DATA;
			bit_cnt_reg <= 5'h00;
		end else if (data_done) begin
			spi_state_reg <= sync_gen_pkg::SPI_DONE;
		end else if (sclk_rise && spi_state_reg != sync_gen_pkg::SPI_DONE) begin
			bit_cnt_reg <= bit_cnt_reg + 5'h01;
		end
	end

	// shifter, instruction latch and read data out on falling edges
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			sclk_prev_reg <= 1'b0;
			shift_reg <= 15'h0000;
			instr_reg <= 16'h0000;
			rd_shift_reg <= 8'h00;
			o_sdo <= 1'b0;
		end else begin
			sclk_prev_reg <= i_sclk;
			if (sclk_rise) begin
				shift_reg <= instr_word[14:0];
			end
			if (instr_done) begin
				instr_reg <= instr_word;
				rd_shift_reg <= read_byte(instr_word[12:0], buf_reg, xfer_pend_reg);
			end else if (sclk_fall && spi_state_reg == sync_gen_pkg::SPI_DATA) begin
				o_sdo <= rd_shift_reg[7];
				rd_shift_reg <= {rd_shift_reg[6:0], 1'b0};
			end
		end
	end

	// buffered register writes
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			buf_reg <= `SYNC_CFG_RESET;
		end else if (wr_fire) begin
			if (wr_addr == `ADDR_SYNC_POLARITY) begin
				buf_reg.polarity <= wr_data[`POL_MAIN_BIT];
			end else if (wr_addr == `ADDR_SYNC_OUTPUT_CMOS_CONFIG) begin
				buf_reg.cmos_pol <= wr_data[`CMOS_POL_BIT];
				buf_reg.cmos_en <= wr_data[`CMOS_EN_HI:`CMOS_EN_LO];
				buf_reg.cmos_mode <= wr_data[`CMOS_MODE_BIT];
				buf_reg.edge_fall <= wr_data[`EDGE_SEL_BIT];
			end else if (wr_addr == `ADDR_SYNC_INTERVAL_LOW) begin
				buf_reg.interval[7:0] <= wr_data;
			end else if (wr_addr == `ADDR_SYNC_INTERVAL_HIGH) begin
				buf_reg.interval[15:8] <= wr_data;
			end else if (wr_addr == `ADDR_SYNC_GENERATOR_CONTROL) begin
				buf_reg.enable <= wr_data[`CTRL_ENABLE_BIT];
				buf_reg.source <= wr_data[`CTRL_SOURCE_HI:`CTRL_SOURCE_LO];
				buf_reg.mode <= wr_data[`CTRL_MODE_HI:`CTRL_MODE_LO];
			end
		end
	end

	// transfer strobe: copy on the next serial rise, then self-clear; a new set wins
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			act_reg <= `SYNC_CFG_RESET;
			xfer_pend_reg <= 1'b0;
		end else begin
			if (xfer_now) begin
				act_reg <= buf_reg;
			end
			if (xfer_set) begin
				xfer_pend_reg <= 1'b1;
			end else if (xfer_now) begin
				xfer_pend_reg <= 1'b0;
			end
		end
	end

	// source selection; 1x powers the sync logic down
	wire sync_powered = !act_reg.source[1];
	wire ref_rise = i_ref_clk && !ref_prev_reg;
	wire fb_rise = i_feedback_divider_output && !fb_prev_reg;
	wire src_step = (act_reg.source == sync_gen_pkg::SRC_FEEDBACK) ? fb_rise : ref_rise;
	wire dist_edge = act_reg.edge_fall ? (!i_dist_clk && dist_prev_reg)
		: (i_dist_clk && !dist_prev_reg);
	wire is_single = (act_reg.mode == sync_gen_pkg::MODE_SINGLE);
	wire is_periodic = (act_reg.mode == sync_gen_pkg::MODE_PERIODIC);
	wire run = sync_powered && act_reg.enable;
	wire lfsr_fb = lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10];

	sync_interval_timer #(
		.WIDTH(16)
	) sync_interval_timer_inst (
		.i_clk(i_clk),
		.i_reset_n(i_reset_n),
		.i_run(run),
		.i_step(src_step),
		.i_limit(act_reg.interval),
		.o_tick(tick)
	);

	// sync clock generation per mode; single shot is one interval wide after one interval
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			ref_prev_reg <= 1'b0;
			fb_prev_reg <= 1'b0;
			dist_prev_reg <= 1'b0;
			enable_prev_reg <= 1'b0;
			raw_reg <= 1'b0;
			lfsr_reg <= `LFSR_SEED;
			shot_state_reg <= sync_gen_pkg::SHOT_IDLE;
		end else begin
			ref_prev_reg <= i_ref_clk;
			fb_prev_reg <= i_feedback_divider_output;
			dist_prev_reg <= i_dist_clk;
			enable_prev_reg <= act_reg.enable;
			if (!run) begin
				raw_reg <= 1'b0;
				shot_state_reg <= sync_gen_pkg::SHOT_IDLE;
			end else if (is_single) begin
				case (shot_state_reg)
					sync_gen_pkg::SHOT_IDLE: begin
						// arm only on an enable that has just been transferred in
						if (!enable_prev_reg) begin
							shot_state_reg <= sync_gen_pkg::SHOT_WAIT;
						end
					end
					sync_gen_pkg::SHOT_WAIT: begin
						if (tick) begin
							raw_reg <= 1'b1;
							shot_state_reg <= sync_gen_pkg::SHOT_HIGH;
						end
					end
					sync_gen_pkg::SHOT_HIGH: begin
						if (tick) begin
							raw_reg <= 1'b0;
							shot_state_reg <= sync_gen_pkg::SHOT_DONE;
						end
					end
					default: begin
						raw_reg <= 1'b0;
					end
				endcase
			end else if (tick) begin
				if (is_periodic) begin
					raw_reg <= !raw_reg;
				end else begin
					raw_reg <= lfsr_reg[15];
					lfsr_reg <= {lfsr_reg[14:0], lfsr_fb};
				end
			end
		end
	end

	// cmos pin polarity: pin a follows main, pin b also flips with the cmos bit
	wire data_a = resamp_reg ^ act_reg.polarity;
	wire data_b = resamp_reg ^ act_reg.polarity ^ act_reg.cmos_pol;

	// resample and output stage; lvpecl drives both legs as a complementary pair
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			resamp_reg <= 1'b0;
			o_sync_a <= 1'b0;
			o_sync_b <= 1'b1;
			o_sync_a_oe <= 1'b1;
			o_sync_b_oe <= 1'b1;
		end else begin
			if (dist_edge) begin
				resamp_reg <= raw_reg;
			end
			if (act_reg.cmos_mode) begin
				o_sync_a <= data_a;
				o_sync_b <= data_b;
				o_sync_a_oe <= act_reg.cmos_en[0];
				o_sync_b_oe <= act_reg.cmos_en[1];
			end else begin
				o_sync_a <= data_a;
				o_sync_b <= !data_a;
				o_sync_a_oe <= 1'b1;
				o_sync_b_oe <= 1'b1;
			end
		end
	end

endmodule : sync_pulse_generator

`default_nettype wire

/* File: sim/sync_pulse_generator_checker.sv */
// port-level assertions for the sync pulse generator
`timescale 1ns/100ps
`default_nettype none

module sync_pulse_generator_checker (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_sclk,
	input wire logic i_cs_n,
	input wire logic i_sdi,
	input wire logic o_sdo,
	input wire logic i_ref_clk,
	input wire logic i_feedback_divider_output,
	input wire logic i_dist_clk,
	input wire logic o_sync_a,
	input wire logic o_sync_a_oe,
	input wire logic o_sync_b,
	input wire logic o_sync_b_oe
);
	logic sclk_reg;
	logic dist_reg;
	logic [5:0] dist_hist_reg;
	logic [5:0] rise_hist_reg;
	logic [4:0] bits_reg;
	logic cause;

	// pins may only move after a dist edge or a transfer on a serial clock rise
	assign cause = |{dist_hist_reg, rise_hist_reg};

	// history is left unreset: reset lasts longer than the six cycles it takes to flush
	always_ff @(posedge i_clk) begin
		sclk_reg <= i_sclk;
		dist_reg <= i_dist_clk;
		dist_hist_reg <= {dist_hist_reg[4:0], i_dist_clk ^ dist_reg};
		rise_hist_reg <= {rise_hist_reg[4:0], i_sclk & ~sclk_reg};
	end

	// serial clock rises seen in the current frame
	always_ff @(posedge i_clk) begin
		if (i_cs_n) begin
			bits_reg <= 5'h00;
		end else if (i_sclk && !sclk_reg && bits_reg != 5'h1f) begin
			bits_reg <= bits_reg + 5'h01;
		end
	end

	default clocking @(posedge i_clk);
	endclocking
	default disable iff (!i_reset_n);

	chk_reset_pins: assert property (disable iff (1'b0) !i_reset_n |=>
		!o_sync_a && o_sync_b && o_sync_a_oe && o_sync_b_oe && !o_sdo)
		else $error("pins not at reset state");
	chk_sdo_on_fall: assert property ($changed(o_sdo) && $past(!i_cs_n) |->
		$past(!i_sclk) && ($past(i_sclk, 2) || $past(i_sclk, 3)))
		else $error("read data moved without a serial clock fall");
	chk_sdo_holds: assert property ($changed(o_sdo) && !i_cs_n |=>
		(i_cs_n || $stable(o_sdo)) [*2]) else $error("read data did not hold");
	chk_sdo_data_phase: assert property ($changed(o_sdo) && $past(!i_cs_n) |->
		bits_reg >= 5'h10) else $error("read data moved in instruction phase");
	chk_pin_a_cause: assert property ($changed(o_sync_a) |-> cause)
		else $error("pin a moved without a cause");
	chk_pin_b_cause: assert property ($changed(o_sync_b) |-> cause)
		else $error("pin b moved without a cause");
	chk_oe_on_transfer: assert property ($changed({o_sync_a_oe, o_sync_b_oe}) |->
		|rise_hist_reg) else $error("enables moved without a transfer");
	chk_quiet_hold: assert property (($stable(i_dist_clk) && !i_sclk) [*6] |->
		$stable({o_sync_a, o_sync_b})) else $error("pins moved while quiet");

	cover property ($rose(o_sync_a) && o_sync_a_oe);
	cover property (o_sync_a_oe && !o_sync_b_oe);
	cover property ($rose(o_sdo));
endmodule : sync_pulse_generator_checker

bind sync_pulse_generator sync_pulse_generator_checker sync_pulse_generator_checker_inst (
	.i_clk(i_clk), .i_reset_n(i_reset_n), .i_sclk(i_sclk), .i_cs_n(i_cs_n), .i_sdi(i_sdi),
	.o_sdo(o_sdo), .i_ref_clk(i_ref_clk), .i_dist_clk(i_dist_clk),
	.i_feedback_divider_output(i_feedback_divider_output), .o_sync_a(o_sync_a),
	.o_sync_a_oe(o_sync_a_oe), .o_sync_b(o_sync_b), .o_sync_b_oe(o_sync_b_oe));

`default_nettype wire

/* File: sim/sync_sink.sv */
// converter-side model: counts sync pin rises and times the gap between them
`timescale 1ns/100ps
`default_nettype none

module sync_sink (
	input wire logic i_clk,
	input wire logic i_clear,
	input wire logic i_pin,
	input wire logic i_oe,
	output logic [7:0] o_rises,
	output logic [15:0] o_period
);
	logic pin_reg;
	logic [15:0] since_reg;
	logic level;

	// a released pin falls to the pull-down level
	assign level = i_oe & i_pin;

	// period is the gap between the last two rises
	always_ff @(posedge i_clk) begin
		pin_reg <= level;
		since_reg <= since_reg + 16'h0001;
		if (i_clear) begin
			o_rises <= 8'h00;
			o_period <= 16'h0000;
			since_reg <= 16'h0000;
		end else if (level && !pin_reg) begin
			o_rises <= o_rises + 8'h01;
			o_period <= since_reg;
			since_reg <= 16'h0001;
		end
	end
endmodule : sync_sink

`default_nettype wire

/* File: sim/test_sync_pulse_generator.sv */
// self-checking bench for the sync pulse generator
`timescale 1ns/100ps
`default_nettype none
`include "sync_gen_defs.svh"

`define CHK(got, exp) begin \
	checks_done++; \
	if ((got) !== (exp)) begin \
		err_total++; \
		$display("Error at %0t: got %h want %h", $time, (got), (exp)); \
	end \
end

module test_sync_pulse_generator;
	localparam logic [7:0] IVAL = 8'h02;
	localparam logic [7:0] CTRL [6] = '{8'h11, 8'h15, 8'h19, 8'h1d, 8'h12, 8'h13};
	// ref toggles every 2 cycles, feedback every 4: a sync period is two intervals
	localparam logic [15:0] PER [6] = '{16'(2 * (IVAL + 1) * 4), 16'(2 * (IVAL + 1) * 8),
		16'h0000, 16'h0000, 16'h0000, 16'h0000};
	localparam logic [5:0] SOME = 6'b110011;
	logic clk = 1'b0;
	logic reset_n, sclk, cs_n, sdi, sdo, clear;
	logic sync_a, sync_a_oe, sync_b, sync_b_oe;
	logic [7:0] phase = 8'h00;
	// lets a scenario stop the resampling clock to prove the pins wait for its edges
	logic dist_on = 1'b1;
	logic [7:0] rises;
	logic [15:0] period;
	int err_total = 0;
	int checks_done = 0;

	always #20 clk = ~clk;
	// slow clocks as levels, moved off the sampling edge
	always @(negedge clk) phase <= phase + 8'h01;

	sync_pulse_generator sync_pulse_generator_inst (.i_clk(clk), .i_reset_n(reset_n),
		.i_sclk(sclk), .i_cs_n(cs_n), .i_sdi(sdi), .o_sdo(sdo), .i_ref_clk(phase[1]),
		.i_feedback_divider_output(phase[2]), .i_dist_clk(phase[0] & dist_on), .o_sync_a(sync_a),
		.o_sync_a_oe(sync_a_oe), .o_sync_b(sync_b), .o_sync_b_oe(sync_b_oe));
	sync_sink sync_sink_inst (.i_clk(clk), .i_clear(clear), .i_pin(sync_a),
		.i_oe(sync_a_oe), .o_rises(rises), .o_period(period));

	// one byte per frame; serial clock halves last three cycles each
	task automatic frame(input logic [23:0] word, output logic [7:0] data);
		data = 8'h00;
		cs_n = 1'b0;
		for (int i = 23; i >= 0; i--) begin
			sdi = word[i];
			repeat (3) @(negedge clk);
			sclk = 1'b1;
			repeat (3) @(negedge clk);
			if (i < 8) data = {data[6:0], sdo};
			sclk = 1'b0;
		end
		repeat (3) @(negedge clk);
		cs_n = 1'b1;
		repeat (3) @(negedge clk);
	endtask : frame

	task automatic wr(input logic [12:0] addr, input logic [7:0] val);
		logic [7:0] unused;
		frame({3'b000, addr, val}, unused);
	endtask : wr

	task automatic rd(input logic [12:0] addr, output logic [7:0] val);
		frame({3'b100, addr, 8'h00}, val);
	endtask : rd

	task automatic pulse_clear();
		clear = 1'b1;
		@(negedge clk);
		clear = 1'b0;
	endtask : pulse_clear

	// the transfer lands on the next frame's first rise, so the sink is cleared before it
	task automatic commit();
		logic [7:0] got;
		wr(`ADDR_TRANSFER, 8'h01);
		pulse_clear();
		rd(`ADDR_TRANSFER, got);
		`CHK(got, 8'h00)
	endtask : commit

	task automatic end_sim();
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : end_sim

	initial begin
		logic [7:0] got;
		logic [1:0] held;
		{reset_n, cs_n, sclk, sdi, clear} = 5'b01001;
		repeat (8) @(negedge clk);
		`CHK({sync_a, sync_b, sync_a_oe, sync_b_oe, sdo}, 5'b01110)
		reset_n = 1'b1;
		wr(`ADDR_SYNC_INTERVAL_LOW, IVAL);
		wr(`ADDR_SYNC_INTERVAL_HIGH, 8'h5a);
		rd(`ADDR_SYNC_INTERVAL_HIGH, got);
		`CHK(got, 8'h5a)
		rd(`ADDR_SYNC_INTERVAL_LOW, got);
		`CHK(got, IVAL)
		wr(`ADDR_SYNC_INTERVAL_HIGH, 8'h00);
		wr(`ADDR_SYNC_OUTPUT_CMOS_CONFIG, 8'h06);
		`CHK({sync_a_oe, sync_b_oe}, 2'b11)
		commit();
		`CHK({sync_a_oe, sync_b_oe}, 2'b10)
		wr(`ADDR_SYNC_POLARITY, 8'h08);
		wr(`ADDR_SYNC_OUTPUT_CMOS_CONFIG, 8'h1e);
		commit();
		`CHK({sync_a, sync_b, sync_a_oe, sync_b_oe}, 4'b1011)
		wr(`ADDR_SYNC_POLARITY, 8'h00);
		wr(`ADDR_SYNC_OUTPUT_CMOS_CONFIG, 8'h00);
		wr(`ADDR_SYNC_GENERATOR_CONTROL, 8'h10);
		commit();
		repeat (300) @(negedge clk);
		`CHK(rises, 8'h01)
		// sources and modes: late edges of the old setting settle before the clear
		for (int i = 0; i < 6; i++) begin
			wr(`ADDR_SYNC_GENERATOR_CONTROL, CTRL[i]);
			commit();
			repeat (10) @(negedge clk);
			pulse_clear();
			repeat (300) @(negedge clk);
			if (SOME[i]) begin
				`CHK(rises != 8'h00, 1'b1)
			end else begin
				`CHK(rises, 8'h00)
			end
			if (PER[i] != 16'h0000) begin
				`CHK(period, PER[i])
			end
		end
		// falling-edge resampling keeps the period; a stopped resampling clock freezes the pins
		wr(`ADDR_SYNC_OUTPUT_CMOS_CONFIG, 8'h01);
		wr(`ADDR_SYNC_GENERATOR_CONTROL, CTRL[0]);
		commit();
		repeat (10) @(negedge clk);
		pulse_clear();
		repeat (300) @(negedge clk);
		`CHK(period, PER[0])
		dist_on = 1'b0;
		repeat (4) @(negedge clk);
		held = {sync_a, sync_b};
		pulse_clear();
		repeat (100) @(negedge clk);
		`CHK({sync_a, sync_b}, held)
		`CHK(rises, 8'h00)
		end_sim();
	end
endmodule : test_sync_pulse_generator

`default_nettype wire
